// ===== design/prog_entry_pkg.sv
// Shared constants and types for the serial programming entry logic
`default_nettype none
package prog_entry_pkg;

   // ------------------------------------------------------------
   // Key and word layout
   // ------------------------------------------------------------
   localparam int          KEY_BITS   = 32;
   // Key value is arbitrary, chosen for this design
   localparam logic [31:0] ENTRY_KEY  = 32'h5A3C_96E1;
   localparam int          WORD_BITS  = 8;
   localparam int          CNT_BITS   = 3;
   localparam logic [2:0]  CNT_LAST   = 3'h7;
   localparam logic [2:0]  CNT_RESET  = 3'h0;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] KEY_RESET  = 32'h0000_0000;
   localparam logic [7:0]  WORD_RESET = 8'h00;
   localparam logic [1:0]  SYNC_RESET = 2'h0;

   // ------------------------------------------------------------
   // Session states of the system side
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_LV_SESSION,
      ST_HV_SESSION
   } session_t;

endpackage
`default_nettype wire

// ===== design/prog_entry_top.sv
// Serial programming entry: high- and low-voltage paths, mode hold, master clear lock
`timescale 1ns/1ps
`default_nettype none
module prog_entry_top (
   // System clock and reset
   input  wire logic       sys_clk_i,
   input  wire logic       reset_i,
   // Programming link pins
   input  wire logic       prog_clock_pin_i,
   input  wire logic       prog_data_pin_i,
   output logic            prog_data_pin_o,
   output logic            prog_data_pin_oe_o,
   input  wire logic       master_clear_pin_i,
   input  wire logic       high_entry_voltage_i,
   // Configuration bits
   input  wire logic       low_voltage_prog_enable_i,
   input  wire logic       master_clear_pin_reset_cfg_i,
   // Mode and reset outputs
   output logic            prog_mode_o,
   output logic            hv_session_o,
   output logic            master_clear_pin_reset_enable_o,
   output logic            lvp_clear_allow_o,
   // Memory-side word port
   output logic [7:0]      rx_word_o,
   output logic            rx_valid_o,
   input  wire logic [7:0] tx_word_i,
   input  wire logic       tx_start_i,
   output logic            tx_busy_o
);

   prog_link_if lnk ();

   prog_entry_pkg::session_t state_r;
   prog_entry_pkg::session_t state_nxt;
   logic [1:0] master_clear_pin_sync_r;
   logic [1:0] hv_sync_r;
   logic [1:0] clk_sync_r;
   logic [1:0] dat_sync_r;
   logic [1:0] lvp_sync_r;
   logic [1:0] key_sync_r;
   logic [1:0] rxt_sync_r;
   logic [1:0] rdt_sync_r;
   logic       rxt_seen_r;
   logic       rdt_seen_r;
   logic       rd_active_r;
   logic [7:0] rd_word_r;
   logic [1:0] dout_sync_r;
   logic [1:0] doe_sync_r;

   // ------------------------------------------------------------
   // Link-clock side
   // ------------------------------------------------------------
   prog_link_shifter u_shifter (
      .prog_clock_i              (prog_clock_pin_i),
      .reset_i                   (reset_i),
      .prog_data_in_i            (prog_data_pin_i),
      .master_clear_i            (master_clear_pin_i),
      .low_voltage_prog_enable_i (low_voltage_prog_enable_i),
      .lnk                       (lnk.link)
   );

   // ------------------------------------------------------------
   // Synchronisers onto the system clock
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         master_clear_pin_sync_r <= prog_entry_pkg::SYNC_RESET;
         hv_sync_r   <= prog_entry_pkg::SYNC_RESET;
         clk_sync_r  <= prog_entry_pkg::SYNC_RESET;
         dat_sync_r  <= prog_entry_pkg::SYNC_RESET;
         lvp_sync_r  <= prog_entry_pkg::SYNC_RESET;
         key_sync_r  <= prog_entry_pkg::SYNC_RESET;
         rxt_sync_r  <= prog_entry_pkg::SYNC_RESET;
         rdt_sync_r  <= prog_entry_pkg::SYNC_RESET;
         dout_sync_r <= prog_entry_pkg::SYNC_RESET;
         doe_sync_r  <= prog_entry_pkg::SYNC_RESET;
      end else begin
         master_clear_pin_sync_r <= {master_clear_pin_sync_r[0], master_clear_pin_i};
         hv_sync_r   <= {hv_sync_r[0], high_entry_voltage_i};
         clk_sync_r  <= {clk_sync_r[0], prog_clock_pin_i};
         dat_sync_r  <= {dat_sync_r[0], prog_data_pin_i};
         lvp_sync_r  <= {lvp_sync_r[0], low_voltage_prog_enable_i};
         key_sync_r  <= {key_sync_r[0], lnk.key_match};
         rxt_sync_r  <= {rxt_sync_r[0], lnk.rx_toggle};
         rdt_sync_r  <= {rdt_sync_r[0], lnk.rd_toggle};
         dout_sync_r <= {dout_sync_r[0], lnk.data_out};
         doe_sync_r  <= {doe_sync_r[0], lnk.data_oe};
      end
   end

   // ------------------------------------------------------------
   // Named decode of the synchronised levels
   // ------------------------------------------------------------
   wire master_clear_pin_low  = ~master_clear_pin_sync_r[1];
   wire hv_high   = hv_sync_r[1];
   wire pins_low  = ~clk_sync_r[1] & ~dat_sync_r[1];
   wire lvp_on    = lvp_sync_r[1];
   wire key_ok    = key_sync_r[1];
   wire hv_entry  = hv_high & pins_low;
   wire lv_entry  = lvp_on & key_ok & master_clear_pin_low;
   wire rx_event  = rxt_sync_r[1] ^ rxt_seen_r;
   wire rd_done   = rdt_sync_r[1] ^ rdt_seen_r;
   wire in_mode   = (state_r != prog_entry_pkg::ST_IDLE);

   // ------------------------------------------------------------
   // Session state
   // ------------------------------------------------------------
   // High voltage wins if both paths qualify, since only it may clear the enable bit
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         prog_entry_pkg::ST_IDLE: begin
            if (hv_entry) begin
               state_nxt = prog_entry_pkg::ST_HV_SESSION;
            end else if (lv_entry) begin
               state_nxt = prog_entry_pkg::ST_LV_SESSION;
            end
         end
         prog_entry_pkg::ST_LV_SESSION: begin
            if (!master_clear_pin_low || !lvp_on) begin
               state_nxt = prog_entry_pkg::ST_IDLE;
            end
         end
         prog_entry_pkg::ST_HV_SESSION: begin
            if (!hv_high) begin
               state_nxt = prog_entry_pkg::ST_IDLE;
            end
         end
         default: state_nxt = prog_entry_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_r <= prog_entry_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ------------------------------------------------------------
   // Mode, master clear lock and enable-clear permission
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_mode_o         <= 1'b0;
         hv_session_o        <= 1'b0;
         master_clear_pin_reset_enable_o <= 1'b1;
         lvp_clear_allow_o   <= 1'b0;
         lnk.mode_on         <= 1'b0;
      end else begin
         prog_mode_o         <= (state_nxt != prog_entry_pkg::ST_IDLE);
         lnk.mode_on         <= (state_nxt != prog_entry_pkg::ST_IDLE);
         hv_session_o        <= (state_nxt == prog_entry_pkg::ST_HV_SESSION);
         master_clear_pin_reset_enable_o <= lvp_on | master_clear_pin_reset_cfg_i;
         lvp_clear_allow_o   <= (state_nxt == prog_entry_pkg::ST_HV_SESSION);
      end
   end

   // ------------------------------------------------------------
   // Word exchange with the memory side
   // ------------------------------------------------------------
   // rd_word_r is held still while rd_active_r stands, so the link side may read it
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         rxt_seen_r  <= 1'b0;
         rdt_seen_r  <= 1'b0;
         rx_valid_o  <= 1'b0;
         rx_word_o   <= prog_entry_pkg::WORD_RESET;
         rd_active_r <= 1'b0;
         rd_word_r   <= prog_entry_pkg::WORD_RESET;
      end else begin
         rxt_seen_r <= rxt_sync_r[1];
         rdt_seen_r <= rdt_sync_r[1];
         rx_valid_o <= rx_event & in_mode;
         if (rx_event && in_mode) begin
            rx_word_o <= lnk.rx_word;
         end
         if (!in_mode || rd_done) begin
            rd_active_r <= 1'b0;
         end else if (tx_start_i && !rd_active_r) begin
            rd_active_r <= 1'b1;
            rd_word_r   <= tx_word_i;
         end
      end
   end

   assign lnk.rd_active = rd_active_r;
   assign lnk.rd_word   = rd_word_r;

   // ------------------------------------------------------------
   // Pin drive, retimed so every output leaves a system flip-flop
   // ------------------------------------------------------------
   // Retiming adds two to three system cycles of lag; the programmer samples a link period later
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         prog_data_pin_o    <= 1'b0;
         prog_data_pin_oe_o <= 1'b0;
         tx_busy_o          <= 1'b0;
      end else begin
         prog_data_pin_o    <= dout_sync_r[1];
         prog_data_pin_oe_o <= doe_sync_r[1] & in_mode;
         tx_busy_o          <= rd_active_r;
      end
   end

   // ------------------------------------------------------------
   // Checks on the system clock
   // ------------------------------------------------------------
   a_lv_needs_enable: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(state_r == prog_entry_pkg::ST_LV_SESSION) |-> $past(lvp_on) && $past(key_ok))
      else $error("low-voltage session entered without enable and key");
   a_lv_hold_master_clear_pin: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      (state_r == prog_entry_pkg::ST_LV_SESSION) && !master_clear_pin_low
         |=> (state_r == prog_entry_pkg::ST_IDLE) ##1 !prog_mode_o)
      else $error("low-voltage session outlived master clear");
   a_lv_mode_held: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      prog_mode_o && !hv_session_o |-> $past(master_clear_pin_low) && $past(lvp_on))
      else $error("low-voltage mode stood with master clear high or enable off");
   a_master_clear_pin_lock: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $past(lvp_on) |-> master_clear_pin_reset_enable_o)
      else $error("master clear reset disabled while enable bit set");
   a_clear_only_hv: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      lvp_clear_allow_o |-> $past(hv_high)
         && !$past(state_r == prog_entry_pkg::ST_LV_SESSION))
      else $error("enable bit clear allowed outside high-voltage session");
   a_hv_entry_pins: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      $rose(state_r == prog_entry_pkg::ST_HV_SESSION) |-> $past(pins_low) && $past(hv_high))
      else $error("high-voltage session entered with clock or data high");
   a_rx_only_mode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      rx_valid_o |-> $past(in_mode) && $past(rx_event))
      else $error("word delivered outside program mode");
   a_oe_only_mode: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      prog_data_pin_oe_o |-> $past(in_mode))
      else $error("data pin driven outside program mode");

endmodule
`default_nettype wire

// ===== design/prog_link_if.sv
// Signals passed between the system side and the link-clock side
`timescale 1ns/1ps
`default_nettype none
interface prog_link_if;
   logic       key_match;   // Link side: full key seen since master clear went low
   logic [7:0] rx_word;     // Link side: last received word, stable after toggle
   logic       rx_toggle;   // Link side: flips once per received word
   logic       mode_on;     // System side: program/verify mode level
   logic [7:0] rd_word;     // System side: word to send, stable while rd_active
   logic       rd_active;   // System side: request to shift rd_word out
   logic       rd_toggle;   // Link side: flips when a send finished
   logic       data_out;    // Link side: data pin output level
   logic       data_oe;     // Link side: data pin output enable

   modport link (
      output key_match, rx_word, rx_toggle, rd_toggle, data_out, data_oe,
      input  mode_on, rd_word, rd_active
   );
   modport core (
      input  key_match, rx_word, rx_toggle, rd_toggle, data_out, data_oe,
      output mode_on, rd_word, rd_active
   );
endinterface
`default_nettype wire

// ===== design/prog_link_shifter.sv
// Link-clock logic: key capture, word receive and word send
`timescale 1ns/1ps
`default_nettype none
module prog_link_shifter (
   // Link clock and reset
   input  wire logic      prog_clock_i,
   input  wire logic      reset_i,
   // Raw pins sampled on the link clock
   input  wire logic      prog_data_in_i,
   input  wire logic      master_clear_i,
   input  wire logic      low_voltage_prog_enable_i,
   // Carrier to the system side
   prog_link_if.link      lnk
);

   logic [1:0]  master_clear_pin_sync_r;
   logic [1:0]  lvp_sync_r;
   logic [1:0]  mode_sync_r;
   logic [1:0]  rd_sync_r;
   logic [31:0] key_r;
   logic [31:0] key_nxt;
   logic [2:0]  rx_cnt_r;
   logic [2:0]  tx_cnt_r;
   logic [7:0]  rx_shift_r;
   logic [7:0]  rx_shift_nxt;
   logic        rd_busy_r;
   wire         master_clear_pin_low  = ~master_clear_pin_sync_r[1];
   wire         mode_l    = mode_sync_r[1];
   wire         rd_req    = rd_sync_r[1];
   // Window including the incoming bit, so a frame that stops on the last key bit still matches
   wire         key_hit   = (key_nxt == prog_entry_pkg::ENTRY_KEY);

   // ------------------------------------------------------------
   // Synchronisers onto the link clock
   // ------------------------------------------------------------
   // Link clock only runs while the programmer shifts a frame, key entry included, so these settle in its first edges
   always_ff @(posedge prog_clock_i or posedge reset_i) begin
      if (reset_i) begin
         master_clear_pin_sync_r <= prog_entry_pkg::SYNC_RESET;
         lvp_sync_r  <= prog_entry_pkg::SYNC_RESET;
         mode_sync_r <= prog_entry_pkg::SYNC_RESET;
         rd_sync_r   <= prog_entry_pkg::SYNC_RESET;
      end else begin
         master_clear_pin_sync_r <= {master_clear_pin_sync_r[0], master_clear_i};
         lvp_sync_r  <= {lvp_sync_r[0], low_voltage_prog_enable_i};
         mode_sync_r <= {mode_sync_r[0], lnk.mode_on};
         rd_sync_r   <= {rd_sync_r[0], lnk.rd_active};
      end
   end

   // ------------------------------------------------------------
   // Key capture, one bit per link clock, first bit lands on top
   // ------------------------------------------------------------
   assign key_nxt      = {key_r[30:0], prog_data_in_i};
   assign rx_shift_nxt = {rx_shift_r[6:0], prog_data_in_i};

   always_ff @(posedge prog_clock_i or posedge reset_i) begin
      if (reset_i) begin
         key_r         <= prog_entry_pkg::KEY_RESET;
         lnk.key_match <= 1'b0;
      end else if (!master_clear_pin_low || !lvp_sync_r[1]) begin
         key_r         <= prog_entry_pkg::KEY_RESET;
         lnk.key_match <= 1'b0;
      end else if (!lnk.key_match) begin
         key_r         <= key_nxt;
         lnk.key_match <= key_hit;
      end
   end

   // ------------------------------------------------------------
   // Word receive and send while the mode stands
   // ------------------------------------------------------------
   // Pin turns round on the first edge that sees rd_req, whatever rx_cnt_r holds, and back one edge after the last bit
   always_ff @(posedge prog_clock_i or posedge reset_i) begin
      if (reset_i) begin
         rx_cnt_r      <= prog_entry_pkg::CNT_RESET;
         tx_cnt_r      <= prog_entry_pkg::CNT_RESET;
         rx_shift_r    <= prog_entry_pkg::WORD_RESET;
         lnk.rx_word   <= prog_entry_pkg::WORD_RESET;
         lnk.rx_toggle <= 1'b0;
         lnk.rd_toggle <= 1'b0;
         lnk.data_out  <= 1'b0;
         lnk.data_oe   <= 1'b0;
         rd_busy_r     <= 1'b0;
      end else if (!mode_l) begin
         rx_cnt_r      <= prog_entry_pkg::CNT_RESET;
         tx_cnt_r      <= prog_entry_pkg::CNT_RESET;
         lnk.data_oe   <= 1'b0;
         rd_busy_r     <= 1'b0;
      end else if (rd_req && !rd_busy_r) begin
         lnk.data_oe   <= 1'b1;
         lnk.data_out  <= lnk.rd_word[prog_entry_pkg::CNT_LAST - tx_cnt_r];
         tx_cnt_r      <= tx_cnt_r + 3'h1;
         if (tx_cnt_r == prog_entry_pkg::CNT_LAST) begin
            rd_busy_r     <= 1'b1;
            lnk.rd_toggle <= ~lnk.rd_toggle;
         end
      end else if (rd_busy_r) begin
         lnk.data_oe   <= 1'b0;
         rd_busy_r     <= rd_req;
      end else begin
         rx_shift_r    <= rx_shift_nxt;
         rx_cnt_r      <= rx_cnt_r + 3'h1;
         if (rx_cnt_r == prog_entry_pkg::CNT_LAST) begin
            lnk.rx_word   <= rx_shift_nxt;
            lnk.rx_toggle <= ~lnk.rx_toggle;
         end
      end
   end

   // ------------------------------------------------------------
   // Checks on the link clock
   // ------------------------------------------------------------
   a_key_needs_lvp: assert property (@(posedge prog_clock_i) disable iff (reset_i)
      lnk.key_match |-> $past(lvp_sync_r[1]) && $past(master_clear_pin_low))
      else $error("key match without enable or with master clear high");
   a_key_exact_match: assert property (@(posedge prog_clock_i) disable iff (reset_i)
      $rose(lnk.key_match) |-> (key_r == prog_entry_pkg::ENTRY_KEY))
      else $error("key match raised without an exact key");
   a_drive_only_mode: assert property (@(posedge prog_clock_i) disable iff (reset_i)
      lnk.data_oe |-> $past(mode_l) && $past(rd_req))
      else $error("data pin driven outside a send");

endmodule
`default_nettype wire

// ===== testbench/prog_programmer_model.sv
// Behavioural programmer that drives the serial programming pins
`timescale 1ns/1ps
`default_nettype none
module prog_programmer_model (
   // Pins driven toward the device
   output logic clk_o,
   output logic dat_o,
   output logic drive_o,
   output logic master_clear_pin_o,
   output logic hv_o
);
   // ------------------------------------------------------------
   // Idle levels
   // ------------------------------------------------------------
   initial begin
      clk_o   = 1'b0;
      dat_o   = 1'b0;
      drive_o = 1'b0;
      master_clear_pin_o  = 1'b1;
      hv_o    = 1'b0;
   end

   // ------------------------------------------------------------
   // Frame tasks
   // ------------------------------------------------------------
   // Clock stands still between frames; data moves after the falling edge only
   task automatic shift(input logic [31:0] val, input int n, input logic drv);
      #3;
      for (int i = n - 1; i >= 0; i--) begin
         drive_o = drv;
         dat_o   = val[i];
         #16 clk_o = 1'b1;
         #16 clk_o = 1'b0;
      end
      drive_o = 1'b0;
   endtask

   // Clock goes low and data takes dat_hi before the high voltage appears
   task automatic hv_entry(input logic dat_hi);
      clk_o   = 1'b0;
      dat_o   = dat_hi;
      drive_o = 1'b1;
      #40 hv_o = 1'b1;
   endtask

   task automatic hv_exit();
      hv_o    = 1'b0;
      drive_o = 1'b0;
   endtask

   // Master clear low first, two lead-in clocks for its sync, then the key
   task automatic lv_entry(input logic [31:0] key);
      master_clear_pin_o = 1'b0;
      #40;
      shift(32'h0, 2, 1'b1);
      shift(key, 32, 1'b1);
   endtask
endmodule
`default_nettype wire

// ===== testbench/serial_program_mode_entry_tb.sv
// Self-checking bench for the serial programming entry logic
`timescale 1ns/1ps
`default_nettype none
module serial_program_mode_entry_tb;
   logic       sys_clk_i, reset_i, low_voltage_prog_enable, cfg, tx_start, idle_r;
   logic       p_clk, p_dat, p_drv, p_master_clear_pin, p_hv, d_out, d_oe;
   logic       mode, hv_s, master_clear_pin_en, clr_ok, rx_v, busy;
   logic [7:0] tx_word, rx_word, rd_bits;
   int         error_cnt, check_count, rd_n, seed_v;
   wire        data_wire;

   // Released line shows a changing pattern so a stale value never matches
   assign data_wire = d_oe ? d_out : (p_drv ? p_dat : idle_r);

   prog_entry_top u_prog_entry_top (
      .sys_clk_i(sys_clk_i), .reset_i(reset_i), .prog_clock_pin_i(p_clk),
      .prog_data_pin_i(data_wire), .prog_data_pin_o(d_out), .prog_data_pin_oe_o(d_oe),
      .master_clear_pin_i(p_master_clear_pin), .high_entry_voltage_i(p_hv),
      .low_voltage_prog_enable_i(low_voltage_prog_enable), .master_clear_pin_reset_cfg_i(cfg), .prog_mode_o(mode),
      .hv_session_o(hv_s), .master_clear_pin_reset_enable_o(master_clear_pin_en), .lvp_clear_allow_o(clr_ok),
      .rx_word_o(rx_word), .rx_valid_o(rx_v), .tx_word_i(tx_word),
      .tx_start_i(tx_start), .tx_busy_o(busy));

   prog_programmer_model u_prog_programmer_model (
      .clk_o(p_clk), .dat_o(p_dat), .drive_o(p_drv), .master_clear_pin_o(p_master_clear_pin), .hv_o(p_hv));

   // ------------------------------------------------------------
   // Clock, idle pattern and read capture
   // ------------------------------------------------------------
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) idle_r <= ~idle_r;

   // Pin lags the link flops by about three system cycles, so sample late
   always @(posedge p_clk) fork
      begin
         #45;
         if (d_oe === 1'b1) begin
            rd_bits = {rd_bits[6:0], d_out};
            rd_n++;
         end
      end
   join_none

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Bounded wait: 0 = mode, 1 = receive strobe, 2 = send busy
   task automatic wait_for(input int sel, input logic want, input int n);
      logic cur;
      for (int k = 0; k < n; k++) begin
         @(negedge sys_clk_i);
         cur = (sel == 0) ? mode : (sel == 1) ? rx_v : busy;
         if (cur === want) return;
      end
      error_cnt++;
      $display("BAD wait %0d expected %0b", sel, want);
      report_and_stop();
   endtask

   task automatic rx_word_check(input logic [7:0] w);
      u_prog_programmer_model.shift({24'h0, w}, 8, 1'b1);
      wait_for(1, 1'b1, 20);
      check("rx_word_o", rx_word, w);
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      low_voltage_prog_enable = 1'b0;
      cfg = 1'b0;
      tx_start = 1'b0;
      tx_word = 8'h00;
      idle_r = 1'b0;
      rd_bits = 8'h00;
      error_cnt = 0;
      check_count = 0;
      rd_n = 0;
      seed_v = $urandom(29061);
      repeat (5) @(negedge sys_clk_i);
      check("master_clear_pin_reset_enable_o", master_clear_pin_en, 1);
      check("prog_mode_o", mode, 0);
      reset_i = 1'b0;
      // Every combination of the two settings, then random ones
      for (int i = 0; i < 8; i++) begin
         low_voltage_prog_enable = (i < 4) ? i[1] : 1'($urandom);
         cfg = (i < 4) ? i[0] : 1'($urandom);
         repeat (5) @(negedge sys_clk_i);
         check("master_clear_pin_reset_enable_o", master_clear_pin_en, low_voltage_prog_enable | cfg);
      end
      // High voltage with data high is refused until data goes low
      low_voltage_prog_enable = 1'b1;
      u_prog_programmer_model.hv_entry(1'b1);
      repeat (8) @(negedge sys_clk_i);
      check("prog_mode_o", mode, 0);
      u_prog_programmer_model.dat_o = 1'b0;
      wait_for(0, 1'b1, 10);
      check("hv_session_o", hv_s, 1);
      check("lvp_clear_allow_o", clr_ok, 1);
      u_prog_programmer_model.shift(32'h0, 2, 1'b1);
      rx_word_check(8'($urandom));
      u_prog_programmer_model.hv_exit();
      wait_for(0, 1'b0, 10);
      // Key table: enable off, one bit wrong, then the exact key
      for (int i = 0; i < 3; i++) begin
         @(negedge sys_clk_i);
         low_voltage_prog_enable = (i != 0);
         cfg = 1'($urandom);
         u_prog_programmer_model.lv_entry((i == 1) ? prog_entry_pkg::ENTRY_KEY ^ 32'h1
                                                   : prog_entry_pkg::ENTRY_KEY);
         repeat (10) @(negedge sys_clk_i);
         check("prog_mode_o", mode, (i == 2));
         if (i < 2) begin
            u_prog_programmer_model.master_clear_pin_o = 1'b1;
            repeat (6) @(negedge sys_clk_i);
         end
      end
      check("hv_session_o", hv_s, 0);
      check("lvp_clear_allow_o", clr_ok, 0);
      check("master_clear_pin_reset_enable_o", master_clear_pin_en, 1);
      u_prog_programmer_model.shift(32'h0, 2, 1'b1);
      rx_word_check(8'h00);
      for (int j = 0; j < 3; j++) rx_word_check(8'($urandom));
      // Send one word back with the data line released by the programmer
      tx_word = 8'($urandom);
      tx_start = 1'b1;
      @(negedge sys_clk_i);
      tx_start = 1'b0;
      wait_for(2, 1'b1, 5);
      rd_n = 0;
      u_prog_programmer_model.shift(32'h0, 12, 1'b0);
      wait_for(2, 1'b0, 20);
      check("read bits", rd_bits, tx_word);
      check("read bit count", rd_n, 8);
      check("prog_mode_o", mode, 1);
      u_prog_programmer_model.master_clear_pin_o = 1'b1;
      wait_for(0, 1'b0, 10);
      report_and_stop();
   end
endmodule
`default_nettype wire
